// *** src/lkbe_cfg.svh ***
// address, bit position and value constants of the legacy keyboard block
// Summary of operation
// - output byte in low eight bits; a port 60h read returns it
// - a port 60h read clears output_buffer_full
// - full output with irq enable drives keyboard or mouse line by aux bit
// - char pending with empty output raises the emulation interrupt
// - port writes except D1h and matching gate A20 data set input full, which interrupts
// - port 60h write clears command_or_data, port 64h write sets it
// - boot flag, inhibit, timeout and parity status bits are writable
// - ports are decoded and lines driven only while emulation is on
// - read-only emulation_irq_status shows any active emulation condition
// - external enable lets controller irq inputs raise emulation irq
// - D1h written to port 64h sets sequence bit, other values clear it
// - keyboard irq input rising edge sets its seen bit; write one clears
// - mouse irq input rising edge sets its seen bit; write one clears
// - during the sequence port 60h data is compared against gate level
// - data written to port 60h or 64h is latched into input byte
// - a port 64h read returns status with no side effect
`ifndef LKBE_CFG_SVH
`define LKBE_CFG_SVH
`define LKBE_OFS_CONTROL 12'h100
`define LKBE_OFS_INPUT   12'h104
`define LKBE_OFS_OUTPUT  12'h108
`define LKBE_OFS_STATUS  12'h10C
`define LKBE_PORT_DATA   16'h0060
`define LKBE_PORT_CMD    16'h0064
`define LKBE_A20_CMD     8'hD1
`define LKBE_A20_DBIT    1
`define LKBE_ST_OBF      0
`define LKBE_ST_IBF      1
`define LKBE_ST_CMD      3
`define LKBE_ST_AUX      5
`define LKBE_CT_EMU      0
`define LKBE_CT_EIRQ     1
`define LKBE_CT_CHP      2
`define LKBE_CT_LEGACY_IRQ_ENABLE    3
`define LKBE_CT_EXT      4
`define LKBE_CT_SEQ      5
`define LKBE_CT_KSEEN    6
`define LKBE_CT_MSEEN    7
`define LKBE_CT_A20      8
`define LKBE_RST_BYTE    8'h00
`define LKBE_RST_WORD    32'h0000_0000
`endif

// *** src/lkbe_pkg.sv ***
// types of the legacy keyboard emulation register block
package lkbe_pkg;
  typedef struct packed {
    logic        emu_on;
    logic        char_pend;
    logic        irq_en;
    logic        ext_en;
    logic        a20_seq;
    logic        kbd_seen;
    logic        mse_seen;
    logic        a20_lvl;
    logic [7:0]  st;
    logic [7:0]  out_byte;
    logic [7:0]  in_byte;
    logic [1:0]  kbd_sync;
    logic [1:0]  mse_sync;
    logic        kbd_prev;
    logic        mse_prev;
    logic        kbd_line;
    logic        mse_line;
    logic        emu_irq;
    logic [31:0] mem_rdata;
    logic [7:0]  io_rdata;
  } lkbe_state_s;
endpackage : lkbe_pkg

// *** src/lkbe_regs.sv ***
// legacy keyboard and mouse emulation registers with port decode
`timescale 1ns/1ps
`include "lkbe_cfg.svh"
module lkbe_regs
  import lkbe_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [11:0] mem_addr,
  input  wire logic        mem_wr,
  input  wire logic        mem_rd,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic        kbc_kbd_irq,
  input  wire logic        kbc_mse_irq,
  output logic             keyboard_irq_line,
  output logic             mouse_irq_line,
  output logic             emu_irq
);

  lkbe_state_s s;
  lkbe_state_s n;
  logic        rd60;
  logic        rd64;
  logic        wr60;
  logic        wr64;
  logic        a20_match;
  logic        kbd_rise;
  logic        mse_rise;

  // port decode, active only while emulation is on
  assign rd60 = io_rd & s.emu_on & (io_addr == `LKBE_PORT_DATA);
  assign rd64 = io_rd & s.emu_on & (io_addr == `LKBE_PORT_CMD);
  assign wr60 = io_wr & s.emu_on & (io_addr == `LKBE_PORT_DATA);
  assign wr64 = io_wr & s.emu_on & (io_addr == `LKBE_PORT_CMD);
  // gate A20 data that matches the current level needs no emulation
  assign a20_match = s.a20_seq
                   & (io_wdata[`LKBE_A20_DBIT] == s.a20_lvl);
  // edge detect behind the two-flop synchronisers
  assign kbd_rise = s.kbd_sync[1] & ~s.kbd_prev;
  assign mse_rise = s.mse_sync[1] & ~s.mse_prev;

  // outputs straight from the state flops
  assign mem_rdata         = s.mem_rdata;
  assign io_rdata          = s.io_rdata;
  assign keyboard_irq_line = s.kbd_line;
  assign mouse_irq_line    = s.mse_line;
  assign emu_irq           = s.emu_irq;

  // next state of the whole block
  always_comb
  begin
    n = s;
    n.kbd_sync = {s.kbd_sync[0], kbc_kbd_irq};
    n.mse_sync = {s.mse_sync[0], kbc_mse_irq};
    n.kbd_prev = s.kbd_sync[1];
    n.mse_prev = s.mse_sync[1];
    // host driver writes over the memory window
    if (mem_wr && mem_addr == `LKBE_OFS_CONTROL)
    begin
      n.emu_on    = mem_wdata[`LKBE_CT_EMU];
      n.char_pend = mem_wdata[`LKBE_CT_CHP];
      n.irq_en    = mem_wdata[`LKBE_CT_LEGACY_IRQ_ENABLE];
      n.ext_en    = mem_wdata[`LKBE_CT_EXT];
      n.a20_seq   = mem_wdata[`LKBE_CT_SEQ];
      n.a20_lvl   = mem_wdata[`LKBE_CT_A20];
      if (mem_wdata[`LKBE_CT_KSEEN])
        n.kbd_seen = 1'b0;
      if (mem_wdata[`LKBE_CT_MSEEN])
        n.mse_seen = 1'b0;
    end
    else if (mem_wr && mem_addr == `LKBE_OFS_INPUT)
    begin
      n.in_byte = mem_wdata[7:0];
    end
    else if (mem_wr && mem_addr == `LKBE_OFS_OUTPUT)
    begin
      n.out_byte = mem_wdata[7:0];
    end
    else if (mem_wr && mem_addr == `LKBE_OFS_STATUS)
    begin
      n.st = mem_wdata[7:0];
    end
    // port events take priority over a same-cycle memory write
    if (rd60)
      n.st[`LKBE_ST_OBF] = 1'b0;
    if (wr64)
    begin
      n.in_byte          = io_wdata;
      n.st[`LKBE_ST_CMD] = 1'b1;
      n.a20_seq          = (io_wdata == `LKBE_A20_CMD);
      if (io_wdata != `LKBE_A20_CMD)
        n.st[`LKBE_ST_IBF] = 1'b1;
    end
    if (wr60)
    begin
      n.in_byte          = io_wdata;
      n.st[`LKBE_ST_CMD] = 1'b0;
      if (!a20_match)
        n.st[`LKBE_ST_IBF] = 1'b1;
    end
    // edges set the seen bits, winning over a clear
    if (kbd_rise)
      n.kbd_seen = 1'b1;
    if (mse_rise)
      n.mse_seen = 1'b1;
    // interrupt lines follow the next state
    n.kbd_line = n.emu_on & n.irq_en & n.st[`LKBE_ST_OBF]
               & ~n.st[`LKBE_ST_AUX];
    n.mse_line = n.emu_on & n.irq_en & n.st[`LKBE_ST_OBF]
               & n.st[`LKBE_ST_AUX];
    n.emu_irq  = (n.emu_on & ((n.char_pend & ~n.st[`LKBE_ST_OBF])
               | n.st[`LKBE_ST_IBF]))
               | (n.ext_en & (n.kbd_seen | n.mse_seen));
    // memory read data, valid the cycle after the strobe
    n.mem_rdata = `LKBE_RST_WORD;
    if (mem_rd && mem_addr == `LKBE_OFS_CONTROL)
    begin
      n.mem_rdata[`LKBE_CT_EMU]   = s.emu_on;
      n.mem_rdata[`LKBE_CT_EIRQ]  = s.emu_irq;
      n.mem_rdata[`LKBE_CT_CHP]   = s.char_pend;
      n.mem_rdata[`LKBE_CT_LEGACY_IRQ_ENABLE] = s.irq_en;
      n.mem_rdata[`LKBE_CT_EXT]   = s.ext_en;
      n.mem_rdata[`LKBE_CT_SEQ]   = s.a20_seq;
      n.mem_rdata[`LKBE_CT_KSEEN] = s.kbd_seen;
      n.mem_rdata[`LKBE_CT_MSEEN] = s.mse_seen;
      n.mem_rdata[`LKBE_CT_A20]   = s.a20_lvl;
    end
    else if (mem_rd && mem_addr == `LKBE_OFS_INPUT)
      n.mem_rdata[7:0] = s.in_byte;
    else if (mem_rd && mem_addr == `LKBE_OFS_OUTPUT)
      n.mem_rdata[7:0] = s.out_byte;
    else if (mem_rd && mem_addr == `LKBE_OFS_STATUS)
      n.mem_rdata[7:0] = s.st;
    // port read data, zero when nothing is decoded
    n.io_rdata = `LKBE_RST_BYTE;
    if (rd60)
      n.io_rdata = s.out_byte;
    else if (rd64)
      n.io_rdata = s.st;
  end

  // state register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= n;
  end

  // checks on the decoded port behaviour, the interrupts and the seen bits
  a_obf_clear: assert property (@(posedge clk)
    disable iff (sys_rst)
    rd60 |=> !s.st[`LKBE_ST_OBF])
    else $error("port 60h read left output full set");
  a_data_read: assert property (@(posedge clk)
    disable iff (sys_rst)
    rd60 |=> io_rdata == $past(s.out_byte))
    else $error("port 60h read returned wrong byte");
  a_kbd_line_level: assert property (@(posedge clk)
    disable iff (sys_rst)
    keyboard_irq_line == (s.emu_on && s.irq_en && s.st[`LKBE_ST_OBF]
                          && !s.st[`LKBE_ST_AUX]))
    else $error("keyboard line does not match status");
  a_mse_line_level: assert property (@(posedge clk)
    disable iff (sys_rst)
    mouse_irq_line == (s.emu_on && s.irq_en && s.st[`LKBE_ST_OBF]
                       && s.st[`LKBE_ST_AUX]))
    else $error("mouse line does not match status");
  a_char_pend_irq: assert property (@(posedge clk)
    disable iff (sys_rst)
    (s.emu_on && s.char_pend && !s.st[`LKBE_ST_OBF]) |-> emu_irq)
    else $error("char pending did not interrupt");
  a_ibf_on_write: assert property (@(posedge clk)
    disable iff (sys_rst)
    (wr60 && !a20_match) |=> s.st[`LKBE_ST_IBF] && emu_irq)
    else $error("data write did not set input full");
  a_cmd_bit_set: assert property (@(posedge clk)
    disable iff (sys_rst)
    wr64 |=> s.st[`LKBE_ST_CMD] && s.in_byte == $past(io_wdata))
    else $error("command write did not set command bit");
  a_no_decode_off: assert property (@(posedge clk)
    disable iff (sys_rst)
    (io_rd && !s.emu_on) |=> io_rdata == `LKBE_RST_BYTE)
    else $error("port answered with emulation off");
  a_status_bit_read: assert property (@(posedge clk)
    disable iff (sys_rst)
    (mem_rd && mem_addr == `LKBE_OFS_CONTROL)
      |=> mem_rdata[`LKBE_CT_EIRQ] == $past(emu_irq))
    else $error("interrupt status bit wrong");
  a_ext_irq_raise: assert property (@(posedge clk)
    disable iff (sys_rst)
    (s.ext_en && (s.kbd_seen || s.mse_seen)) |-> emu_irq)
    else $error("external edge did not interrupt");
  a_a20_seq_set: assert property (@(posedge clk)
    disable iff (sys_rst)
    wr64 |=> s.a20_seq == ($past(io_wdata) == `LKBE_A20_CMD))
    else $error("sequence bit wrong after command");
  a_kbd_edge_seen: assert property (@(posedge clk)
    disable iff (sys_rst)
    kbd_rise |=> s.kbd_seen)
    else $error("keyboard edge lost");
  a_mse_edge_seen: assert property (@(posedge clk)
    disable iff (sys_rst)
    mse_rise |=> s.mse_seen)
    else $error("mouse edge lost");
  a_a20_match_quiet: assert property (@(posedge clk)
    disable iff (sys_rst)
    (wr60 && a20_match && !s.st[`LKBE_ST_IBF] && !mem_wr)
      |=> !s.st[`LKBE_ST_IBF])
    else $error("matching gate data set input full");
  a_status_read_pure: assert property (@(posedge clk)
    disable iff (sys_rst)
    (rd64 && !mem_wr) |=> io_rdata == $past(s.st)
      && s.st[`LKBE_ST_OBF] == $past(s.st[`LKBE_ST_OBF]))
    else $error("status read had a side effect");

  // checks on the input byte and on software-side writes
  a_input_latch: assert property (@(posedge clk)
    disable iff (sys_rst)
    wr60 |=> s.in_byte == $past(io_wdata) && !s.st[`LKBE_ST_CMD])
    else $error("data write not latched into input byte");
  a_status_write: assert property (@(posedge clk)
    disable iff (sys_rst)
    (mem_wr && mem_addr == `LKBE_OFS_STATUS && !rd60 && !wr60 && !wr64)
      |=> s.st == $past(mem_wdata[7:0]))
    else $error("status write not kept");
  a_kbd_seen_clear: assert property (@(posedge clk)
    disable iff (sys_rst)
    (mem_wr && mem_addr == `LKBE_OFS_CONTROL
      && mem_wdata[`LKBE_CT_KSEEN] && !kbd_rise) |=> !s.kbd_seen)
    else $error("keyboard seen bit not cleared");

endmodule : lkbe_regs

// *** test/lkbe_kbc_model.sv ***
// keyboard controller model driving its two interrupt pins
`timescale 1ns/1ps
module lkbe_kbc_model (
  input  wire logic clk,
  output logic      kbd_irq,
  output logic      mse_irq
);
  // both pins idle low between requests
  initial
  begin
    kbd_irq = 1'b0;
    mse_irq = 1'b0;
  end
  // one rising edge on the chosen pin, held four cycles
  task automatic pulse(input logic sel);
  begin
    @(negedge clk);
    if (sel)
      mse_irq = 1'b1;
    else
      kbd_irq = 1'b1;
    repeat (4) @(negedge clk);
    mse_irq = 1'b0;
    kbd_irq = 1'b0;
  end
  endtask : pulse
endmodule : lkbe_kbc_model

// *** test/tb_lkbe_regs.sv ***
// self-checking bench of the legacy keyboard emulation registers
`timescale 1ns/1ps
module tb_lkbe_regs;
  logic        clk, sys_rst, mem_wr, mem_rd, io_wr, io_rd;
  logic [11:0] mem_addr;
  logic [31:0] mem_wdata, mem_rdata, q;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata;
  logic        kbd_irq, mse_irq, kbd_line, mse_line, emu_irq;
  int          mismatches = 0;
  int          n_compared = 0;
  int          i;
  // kind (0 mem wr, 1 mem rd, 2 io wr, 3 io rd), address, data, expected
  localparam logic [81:0] rows [25] = '{
    {2'h1, 16'h0100, 32'h0, 32'h0},
    {2'h3, 16'h0064, 32'h0, 32'h0},
    {2'h2, 16'h0060, 32'h77, 32'h0},
    {2'h1, 16'h010C, 32'h0, 32'h0},
    {2'h0, 16'h0100, 32'h1, 32'h0},
    {2'h0, 16'h0108, 32'h5A, 32'h0},
    {2'h0, 16'h010C, 32'h21, 32'h0},
    {2'h1, 16'h010C, 32'h0, 32'h21},
    {2'h3, 16'h0064, 32'h0, 32'h21},
    {2'h3, 16'h0060, 32'h0, 32'h5A},
    {2'h3, 16'h0064, 32'h0, 32'h20},
    {2'h2, 16'h0060, 32'h33, 32'h0},
    {2'h3, 16'h0064, 32'h0, 32'h22},
    {2'h1, 16'h0104, 32'h0, 32'h33},
    {2'h1, 16'h0100, 32'h0, 32'h3},
    {2'h2, 16'h0064, 32'hD1, 32'h0},
    {2'h1, 16'h010C, 32'h0, 32'h2A},
    {2'h1, 16'h0100, 32'h0, 32'h23},
    {2'h0, 16'h010C, 32'hD4, 32'h0},
    {2'h1, 16'h010C, 32'h0, 32'hD4},
    {2'h2, 16'h0060, 32'h2, 32'h0},
    {2'h1, 16'h010C, 32'h0, 32'hD6},
    {2'h2, 16'h0064, 32'hAB, 32'h0},
    {2'h1, 16'h0100, 32'h0, 32'h3},
    {2'h1, 16'h0200, 32'h0, 32'h0}
  };
  lkbe_regs i_lkbe_regs (.clk(clk), .sys_rst(sys_rst), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .kbc_kbd_irq(kbd_irq),
    .kbc_mse_irq(mse_irq), .keyboard_irq_line(kbd_line),
    .mouse_irq_line(mse_line), .emu_irq(emu_irq));
  lkbe_kbc_model i_lkbe_kbc_model (.clk(clk), .kbd_irq(kbd_irq),
    .mse_irq(mse_irq));
  // 100 ns clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // counts a compare and reports a difference
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask : chk
  // one strobe cycle on memory or port side, read data taken after it
  task automatic acc(input logic [1:0] k, input logic [15:0] a,
                     input logic [31:0] d, output logic [31:0] r);
  begin
    @(negedge clk);
    mem_addr = a[11:0];
    io_addr = a;
    mem_wdata = d;
    io_wdata = d[7:0];
    {io_rd, io_wr, mem_rd, mem_wr} = 4'h1 << k;
    @(negedge clk);
    {io_rd, io_wr, mem_rd, mem_wr} = 4'h0;
    r = k[1] ? {24'h0, io_rdata} : mem_rdata;
  end
  endtask : acc
  // waits a bounded time for the emulation interrupt
  task automatic wait_irq;
  begin
    for (i = 0; i < 20 && emu_irq !== 1'b1; i++)
      @(negedge clk);
    chk({31'h0, emu_irq}, 32'h1);
    if (emu_irq !== 1'b1)
      results();
  end
  endtask : wait_irq
  // verdict and end of run
  task automatic results;
  begin
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask : results
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    {mem_wr, mem_rd, io_wr, io_rd} = 4'h0;
    mem_addr = 12'h000;
    mem_wdata = 32'h0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    foreach (rows[r])
    begin
      acc(rows[r][81:80], rows[r][79:64], rows[r][63:32], q);
      if (rows[r][80])
        chk(q, rows[r][31:0]);
    end
    $display("table rows done");
    acc(2'h0, 16'h010C, 32'h01, q);
    acc(2'h0, 16'h0100, 32'h09, q);
    chk({30'h0, kbd_line, mse_line}, 32'h2);
    acc(2'h0, 16'h010C, 32'h21, q);
    chk({30'h0, kbd_line, mse_line}, 32'h1);
    acc(2'h3, 16'h0060, 32'h0, q);
    chk({30'h0, kbd_line, mse_line}, 32'h0);
    acc(2'h0, 16'h0100, 32'h05, q);
    chk({31'h0, emu_irq}, 32'h1);
    acc(2'h0, 16'h010C, 32'h01, q);
    chk({31'h0, emu_irq}, 32'h0);
    $display("irq line test done");
    acc(2'h0, 16'h0100, 32'h10, q);
    i_lkbe_kbc_model.pulse(1'b0);
    wait_irq();
    acc(2'h1, 16'h0100, 32'h0, q);
    chk(q, 32'h52);
    acc(2'h0, 16'h0100, 32'h50, q);
    acc(2'h1, 16'h0100, 32'h0, q);
    chk(q, 32'h10);
    i_lkbe_kbc_model.pulse(1'b1);
    wait_irq();
    acc(2'h0, 16'h0100, 32'h10, q);
    acc(2'h1, 16'h0100, 32'h0, q);
    chk(q, 32'h92);
    acc(2'h0, 16'h0100, 32'h90, q);
    acc(2'h1, 16'h0100, 32'h0, q);
    chk(q, 32'h10);
    $display("external edge test done");
    acc(2'h0, 16'h0100, 32'h101, q);
    acc(2'h0, 16'h010C, 32'h00, q);
    acc(2'h2, 16'h0064, 32'hD1, q);
    acc(2'h3, 16'h0064, 32'h0, q);
    chk(q, 32'h08);
    acc(2'h2, 16'h0060, 32'h02, q);
    acc(2'h3, 16'h0064, 32'h0, q);
    chk(q, 32'h00);
    acc(2'h1, 16'h0104, 32'h0, q);
    chk(q, 32'h02);
    acc(2'h1, 16'h0100, 32'h0, q);
    chk(q, 32'h121);
    $display("gate sequence test done");
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    acc(2'h1, 16'h0100, 32'h0, q);
    chk(q, 32'h0);
    $display("reset test done");
    results();
  end
endmodule : tb_lkbe_regs
